// ===== core/ramp_time_select_start_hold.sv
// Purpose: ramp time set selection, time scaling and start frequency hold
// Assumes: apb slave with one wait state, pins pass a three stage filter
// Notes: ramp shaping itself lives downstream; this block hands it times
// Operation
// - increment change rescales stored ramp times tenfold
// - restart acceleration time unaffected by increment
// - second pair on second select, third on third
// - both selects active: third pair wins
// - decel sentinel 9999 uses matching accel time (second and third sets only; primary decel 9999 is used as stored)
// - third accel 9999 disables third set
// - third select from terminal coded 9
// - second select: dedicated pin or code 3
// - s-pattern A time refers to base frequency
// - s-pattern A above base: 4/9 scaled plus 5/9
// - scalar control: 0.03 s or less gives 0.04 s
// - reference frequency write leaves analog gains alone
// - starting frequency 0 to 60 Hz, default 0.5
// - no start while command below starting frequency
// - hold time 0 to 10 s, 9999 disables
// - hold starting frequency for hold time
// - zero starting frequency holds at 0.01 Hz
// - start off during hold: decelerate at once
// - reversal applies starting frequency, skips hold
// - starting at or below minimum: start alone runs
// - increment 0: 0.1 s steps; 1: 0.01 s
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module ramp_time_select_start_hold
  import ramp_ctl_pkg::*;
#(
  parameter int HOLD_TICK_CYCLES = HOLD_STEP_CYCLES
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // input terminals
  input wire logic second_function_select,
  input wire logic [N_TERMS-1:0] input_terms,
  input wire logic start_in,
  input wire logic reverse_in,
  // drive stage
  output logic [15:0] out_freq,
  output logic running,
  output logic start_holding,
  output logic decelerating,
  output logic [31:0] active_accel_time,
  output logic [31:0] active_decel_time
);

  // ***********************************************
  // functions
  // ***********************************************
  function automatic logic [31:0] scale_time(input logic [15:0] code, input logic fine);
    return fine ? {16'h0000, code} : {16'h0000, code} * COARSE_SCALE;
  endfunction

  function automatic logic [31:0] clamp_time(input logic [31:0] t, input logic en);
    return (en && t <= CLAMP_LIMIT) ? CLAMP_VALUE : t;
  endfunction

  function automatic logic code_match(input logic [31:0] codes, input logic [N_TERMS-1:0] lvl,
                                      input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_TERMS; i++) begin
      hit = hit | (lvl[i] & (codes[8*i +: 8] == code));
    end
    return hit;
  endfunction

  function automatic logic [31:0] s_time(input logic [31:0] t, input logic [15:0] f,
                                         input logic [15:0] fb);
    logic [63:0] ratio;
    logic [63:0] prod;
    ratio = 64'h0;
    prod = 64'h0;
    if (fb != ZERO16) begin
      ratio = ({32'h0, {16'h0000, f} * {16'h0000, f}} << FRAC_BITS)
              / {32'h0, {16'h0000, fb} * {16'h0000, fb}};
      prod = {32'h0, t} * (ratio * FORM_A + (FORM_B << FRAC_BITS));
      prod = prod / (FORM_DEN << FRAC_BITS);
    end
    return prod[31:0];
  endfunction

  // ***********************************************
  // registers
  // ***********************************************
  logic [2:0] ctrl_q;
  logic [15:0] t1a_q, t1d_q, t2a_q, t2d_q, t3a_q, t3d_q;
  logic [15:0] restart_q, base_q, ref_q, start_freq_q, min_freq_q, hold_q;
  logic [15:0] gain_a_q, gain_b_q, cmd_q;
  logic [31:0] term_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [N_PINS-1:0] s1_q, s2_q, s3_q, filt_q;
  run_state_e st_q;
  time_set_e set_q;
  logic [15:0] out_q;
  logic [31:0] acc_q, dec_q, pre_q;
  logic [15:0] hold_left_q;
  logic dir_q;

  // ***********************************************
  // pin filtering
  // ***********************************************
  wire [N_PINS-1:0] pins = {reverse_in, start_in, input_terms, second_function_select};
  wire [N_PINS-1:0] agree = ~(s2_q ^ s3_q);
  wire [N_PINS-1:0] filt_d = (s2_q & agree) | (filt_q & ~agree);
  wire f_second = filt_q[0];
  wire [N_TERMS-1:0] f_terms = filt_q[N_TERMS:1];
  wire f_start = filt_q[N_TERMS+1];
  wire f_rev = filt_q[N_TERMS+2];

  // ***********************************************
  // time set selection
  // ***********************************************
  wire fine = ctrl_q[CTRL_INC_BIT];
  wire spat = ctrl_q[CTRL_SPAT_BIT];
  wire scalar = ctrl_q[CTRL_SCALAR_BIT];
  wire sel2 = f_second | code_match(term_q, f_terms, FUNC_SECOND);
  wire sel3 = code_match(term_q, f_terms, FUNC_THIRD);
  wire third_ok = sel3 && (t3a_q != SENTINEL);
  wire time_set_e set_d = third_ok ? SET_THIRD :
                          sel2 ? SET_SECOND : SET_PRIMARY;
  wire [15:0] acc_code = (set_d == SET_THIRD) ? t3a_q :
                         (set_d == SET_SECOND) ? t2a_q : t1a_q;
  wire [15:0] dec_code = (set_d == SET_THIRD) ? ((t3d_q == SENTINEL) ? t3a_q : t3d_q) :
                         (set_d == SET_SECOND) ? ((t2d_q == SENTINEL) ? t2a_q : t2d_q) :
                         t1d_q;
  // stored code times the step size; flipping the step rescales all sets
  wire [31:0] acc_base = scale_time(acc_code, fine);
  wire [31:0] dec_base = scale_time(dec_code, fine);
  // set time counts to base frequency in s-pattern A
  wire use_s = spat && (cmd_q >= base_q);
  wire [31:0] acc_s = use_s ? s_time(acc_base, cmd_q, base_q) : acc_base;
  wire [31:0] dec_s = use_s ? s_time(dec_base, cmd_q, base_q) : dec_base;
  wire [31:0] acc_d = clamp_time(acc_s, scalar);
  wire [31:0] dec_d = clamp_time(dec_s, scalar);

  // ***********************************************
  // start control
  // ***********************************************
  wire low_start = start_freq_q <= min_freq_q;
  wire can_start = f_start && ((cmd_q >= start_freq_q) || low_start);
  wire [15:0] tgt = (cmd_q < min_freq_q) ? min_freq_q : cmd_q;
  wire [15:0] hold_freq = (start_freq_q == ZERO16) ? HOLD_FREQ_MIN : start_freq_q;
  wire hold_en = hold_q != SENTINEL;
  wire tick = pre_q == 32'(HOLD_TICK_CYCLES - 1);
  wire hold_done = hold_left_q == ZERO16;

  // ***********************************************
  // apb decode
  // ***********************************************
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_t1 = paddr == OFS_T1;
  wire hit_t2 = paddr == OFS_T2;
  wire hit_t3 = paddr == OFS_T3;
  wire hit_rst = paddr == OFS_RESTART;
  wire hit_base = paddr == OFS_BASE;
  wire hit_start = paddr == OFS_START;
  wire hit_hold = paddr == OFS_HOLD;
  wire hit_gain = paddr == OFS_GAIN;
  wire hit_term = paddr == OFS_TERM;
  wire hit_cmd = paddr == OFS_CMD;
  wire hit_stat = paddr == OFS_STATUS;
  wire hit_acc = paddr == OFS_ACC;
  wire hit_dec = paddr == OFS_DEC;
  wire mapped = hit_ctrl | hit_t1 | hit_t2 | hit_t3 | hit_rst | hit_base | hit_start |
                hit_hold | hit_gain | hit_term | hit_cmd | hit_stat | hit_acc | hit_dec;
  wire access = psel && penable;
  wire wr = access && pready_q && pwrite && mapped;
  wire [15:0] wlo = pwdata[15:0];
  wire [15:0] whi = pwdata[31:16];
  wire lo_ok = wlo <= TIME_CODE_MAX;
  wire hi_ok = whi <= TIME_CODE_MAX;
  wire sf_ok = wlo <= START_FREQ_MAX;
  wire hold_ok = (wlo <= HOLD_MAX) || (wlo == SENTINEL);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_ctrl) begin
      rd_mux = {29'h0, ctrl_q};
    end else if (hit_t1) begin
      rd_mux = {t1d_q, t1a_q};
    end else if (hit_t2) begin
      rd_mux = {t2d_q, t2a_q};
    end else if (hit_t3) begin
      rd_mux = {t3d_q, t3a_q};
    end else if (hit_rst) begin
      rd_mux = {16'h0000, restart_q};
    end else if (hit_base) begin
      rd_mux = {ref_q, base_q};
    end else if (hit_start) begin
      rd_mux = {min_freq_q, start_freq_q};
    end else if (hit_hold) begin
      rd_mux = {16'h0000, hold_q};
    end else if (hit_gain) begin
      rd_mux = {gain_b_q, gain_a_q};
    end else if (hit_term) begin
      rd_mux = term_q;
    end else if (hit_cmd) begin
      rd_mux = {16'h0000, cmd_q};
    end else if (hit_stat) begin
      rd_mux = {6'h00, f_rev, f_start, set_q, st_q, 4'h0, out_q};
    end else if (hit_acc) begin
      rd_mux = acc_q;
    end else if (hit_dec) begin
      rd_mux = dec_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (ce) begin
      pready_q <= access && !pready_q;
      pslverr_q <= access && !pready_q && !mapped;
      if (access && !pready_q) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // ***********************************************
  // register file
  // ***********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      t1a_q <= TIME_RST;
      t1d_q <= TIME_RST;
      t2a_q <= TIME_RST;
      t2d_q <= SENTINEL;
      t3a_q <= SENTINEL;
      t3d_q <= SENTINEL;
      restart_q <= RESTART_RST;
      base_q <= FREQ_60_RST;
      ref_q <= FREQ_60_RST;
      start_freq_q <= START_FREQ_RST;
      min_freq_q <= ZERO16;
      hold_q <= SENTINEL;
      gain_a_q <= FREQ_60_RST;
      gain_b_q <= FREQ_60_RST;
      term_q <= 32'h00000000;
      cmd_q <= ZERO16;
    end else if (ce && wr) begin
      // restart time is kept in fixed units and never rescaled
      if (hit_ctrl) ctrl_q <= pwdata[2:0];
      if (hit_t1 && lo_ok && hi_ok) t1a_q <= wlo;
      if (hit_t1 && lo_ok && hi_ok) t1d_q <= whi;
      if (hit_t2 && lo_ok && hi_ok) t2a_q <= wlo;
      if (hit_t2 && lo_ok && hi_ok) t2d_q <= whi;
      if (hit_t3 && lo_ok && hi_ok) t3a_q <= wlo;
      if (hit_t3 && lo_ok && hi_ok) t3d_q <= whi;
      if (hit_rst) restart_q <= wlo;
      if (hit_base) base_q <= wlo;
      if (hit_base) ref_q <= whi;
      if (hit_start && sf_ok) start_freq_q <= wlo;
      if (hit_start) min_freq_q <= whi;
      if (hit_hold && hold_ok) hold_q <= wlo;
      if (hit_gain) gain_a_q <= wlo;
      if (hit_gain) gain_b_q <= whi;
      if (hit_term) term_q <= pwdata;
      if (hit_cmd) cmd_q <= wlo;
    end
  end

  // ***********************************************
  // pins, time outputs, run sequence
  // ***********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      set_q <= SET_PRIMARY;
      acc_q <= 32'h00000000;
      dec_q <= 32'h00000000;
    end else if (ce) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      set_q <= set_d;
      acc_q <= acc_d;
      dec_q <= dec_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_STOP;
      out_q <= ZERO16;
      pre_q <= 32'h00000000;
      hold_left_q <= ZERO16;
      dir_q <= 1'b0;
    end else if (ce) begin
      pre_q <= (st_q != ST_HOLD || tick) ? 32'h00000000 : pre_q + 32'h00000001;
      case (st_q)
        ST_STOP: begin
          out_q <= ZERO16;
          if (can_start) begin
            dir_q <= f_rev;
            if (hold_en) begin
              st_q <= ST_HOLD;
              out_q <= hold_freq;
              hold_left_q <= hold_q;
            end else begin
              st_q <= ST_RUN;
              out_q <= start_freq_q;
            end
          end
        end
        ST_HOLD: begin
          out_q <= hold_freq;
          if (!f_start) begin
            st_q <= ST_DECEL;
          end else if (hold_done) begin
            st_q <= ST_RUN;
          end else if (tick) begin
            hold_left_q <= hold_left_q - 16'h0001;
          end
        end
        ST_RUN: begin
          if (!f_start) begin
            st_q <= ST_DECEL;
          end else if (f_rev != dir_q) begin
            dir_q <= f_rev;
            out_q <= start_freq_q;
          end else begin
            out_q <= tgt;
          end
        end
        default: begin
          out_q <= ZERO16;
          st_q <= ST_STOP;
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign out_freq = out_q;
  assign running = st_q[1] & st_q[0];
  assign start_holding = st_q == ST_HOLD;
  assign decelerating = st_q == ST_DECEL;
  assign active_accel_time = acc_q;
  assign active_decel_time = dec_q;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hold_entry;
    st_q == ST_STOP && ce && can_start && hold_en ##1 st_q == ST_HOLD;
  endsequence

  property p_third_prio;
    ce && sel2 && third_ok |=> set_q == SET_THIRD;
  endproperty
  a_third_prio: assert property (p_third_prio) else $error("third set lost priority");

  property p_second_set;
    ce && sel2 && !third_ok |=> set_q == SET_SECOND;
  endproperty
  a_second_set: assert property (p_second_set) else $error("second set not used");

  property p_primary_set;
    ce && !sel2 && !third_ok |=> set_q == SET_PRIMARY;
  endproperty
  a_primary_set: assert property (p_primary_set) else $error("primary set not used");

  property p_third_off;
    ce && t3a_q == SENTINEL |=> set_q != SET_THIRD;
  endproperty
  a_third_off: assert property (p_third_off) else $error("disabled third set chosen");

  property p_dec_follow;
    ce && third_ok && t3d_q == SENTINEL |=> dec_q == acc_q;
  endproperty
  a_dec_follow: assert property (p_dec_follow) else $error("decel not equal accel");

  property p_clamp;
    ce && scalar && acc_s <= CLAMP_LIMIT |=> acc_q == CLAMP_VALUE;
  endproperty
  a_clamp: assert property (p_clamp) else $error("short time not clamped");

  property p_restart_keep;
    ce && wr && hit_ctrl |=> restart_q == $past(restart_q);
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("restart time moved");

  property p_no_start;
    st_q == ST_STOP && !can_start |=> st_q == ST_STOP && out_q == ZERO16;
  endproperty
  a_no_start: assert property (p_no_start) else $error("started below start freq");

  property p_hold_abort;
    st_q == ST_HOLD && ce && !f_start |=> st_q == ST_DECEL ##1 st_q == ST_STOP;
  endproperty
  a_hold_abort: assert property (p_hold_abort) else $error("hold not abandoned");

  property p_hold_freq;
    s_hold_entry |-> out_q == $past(hold_freq);
  endproperty
  a_hold_freq: assert property (p_hold_freq) else $error("wrong hold frequency");

  property p_reverse;
    st_q == ST_RUN && ce && f_start && f_rev != dir_q |=> st_q == ST_RUN &&
      out_q == $past(start_freq_q);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reversal mishandled");

endmodule

// ===== core/ramp_ctl_pkg.sv
// Purpose: shared constants for the ramp time select and start hold block
// Assumes: times in 0.01 s units internally, frequencies in 0.01 Hz units
// Notes: ramp time registers hold a code scaled by the increment select
package ramp_ctl_pkg;

  // ***********************************************
  // register map (byte offsets)
  // ***********************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_T1 = 8'h04;
  localparam logic [7:0] OFS_T2 = 8'h08;
  localparam logic [7:0] OFS_T3 = 8'h0C;
  localparam logic [7:0] OFS_RESTART = 8'h10;
  localparam logic [7:0] OFS_BASE = 8'h14;
  localparam logic [7:0] OFS_START = 8'h18;
  localparam logic [7:0] OFS_HOLD = 8'h1C;
  localparam logic [7:0] OFS_GAIN = 8'h20;
  localparam logic [7:0] OFS_TERM = 8'h24;
  localparam logic [7:0] OFS_CMD = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_ACC = 8'h30;
  localparam logic [7:0] OFS_DEC = 8'h34;

  // ***********************************************
  // fields and values
  // ***********************************************
  localparam int CTRL_INC_BIT = 0;
  localparam int CTRL_SPAT_BIT = 1;
  localparam int CTRL_SCALAR_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h4;
  localparam logic [15:0] SENTINEL = 16'h270F;
  localparam logic [15:0] TIME_CODE_MAX = 16'h8CA0;
  localparam logic [31:0] COARSE_SCALE = 32'h0000000A;
  localparam logic [31:0] CLAMP_LIMIT = 32'h00000003;
  localparam logic [31:0] CLAMP_VALUE = 32'h00000004;
  localparam logic [15:0] START_FREQ_MAX = 16'h1770;
  localparam logic [15:0] START_FREQ_RST = 16'h0032;
  localparam logic [15:0] HOLD_MAX = 16'h0064;
  localparam logic [15:0] HOLD_FREQ_MIN = 16'h0001;
  localparam logic [15:0] TIME_RST = 16'h0032;
  localparam logic [15:0] RESTART_RST = 16'h01F4;
  localparam logic [15:0] FREQ_60_RST = 16'h1770;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] FUNC_SECOND = 8'h03;
  localparam logic [7:0] FUNC_THIRD = 8'h09;
  localparam int N_TERMS = 4;
  localparam int N_PINS = 7;

  // ***********************************************
  // s-pattern formula and timing
  // ***********************************************
  localparam logic [63:0] FORM_A = 64'h4;
  localparam logic [63:0] FORM_B = 64'h5;
  localparam logic [63:0] FORM_DEN = 64'h9;
  localparam int FRAC_BITS = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int HOLD_STEP_NS = 100000000;
  localparam int HOLD_STEP_CYCLES = HOLD_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b11,
    ST_DECEL = 2'b10
  } run_state_e;

  typedef enum logic [1:0] {
    SET_PRIMARY = 2'b00,
    SET_SECOND = 2'b01,
    SET_THIRD = 2'b10
  } time_set_e;

endpackage

// ===== testbench/term_drive_model.sv
// Purpose: input terminal and drive stage stand-in
// Assumes: terminal levels change just after a rising edge
// Notes: measures how many cycles each start hold lasts
`timescale 1ns/10ps
module term_drive_model
  import ramp_ctl_pkg::*;
(
  // clock
  input wire logic pclk,
  // requests from the bench
  input wire logic req_second,
  input wire logic [N_TERMS-1:0] req_terms,
  input wire logic req_start,
  input wire logic req_rev,
  // terminals
  output logic second_function_select,
  output logic [N_TERMS-1:0] input_terms,
  output logic start_in,
  output logic reverse_in,
  // drive stage view
  input wire logic start_holding,
  output logic [15:0] hold_len
);
  logic [15:0] cnt_q;

  initial begin
    second_function_select = 1'b0;
    input_terms = '0;
    start_in = 1'b0;
    reverse_in = 1'b0;
    cnt_q = 16'h0;
    hold_len = 16'h0;
  end

  always @(posedge pclk) begin
    second_function_select <= req_second;
    input_terms <= req_terms;
    start_in <= req_start;
    reverse_in <= req_rev;
    if (start_holding === 1'b1) begin
      cnt_q <= cnt_q + 16'h1;
    end else if (cnt_q != 16'h0) begin
      hold_len <= cnt_q;
      cnt_q <= 16'h0;
    end
  end
endmodule

// ===== testbench/ramp_time_select_start_hold_tb_top.sv
// Purpose: self-checking bench for ramp time select and start hold
// Assumes: apb master per transfer, hold tick shortened to 4 cycles
// Notes: terminals reach the block through the terminal model
`timescale 1ns/10ps
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin n_fail++; \
  $display("Error %0t: mismatch got %h exp %h", $time, (g), (x)); end end
module ramp_time_select_start_hold_tb_top;
  import ramp_ctl_pkg::*;
  localparam int TICK = 4;
  localparam logic [4:0] SEL [5] = '{5'h10, 5'h01, 5'h11, 5'h02, 5'h00};
  localparam logic [31:0] EXA [5] = '{32'hC8, 32'h12C, 32'h12C, 32'hC8, 32'h1F4};
  localparam logic [31:0] EXD [5] = '{32'hC8, 32'h190, 32'h190, 32'hC8, 32'h1F4};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, acc_t, dec_t, r;
  logic second_function_select, start_in, reverse_in, running, start_holding, decelerating;
  logic req_second, req_start, req_rev, saw_s, saw_h, ce;
  logic [3:0] req_terms, input_terms;
  logic [15:0] out_freq, hold_len;
  int n_fail, tests_run;

  ramp_time_select_start_hold #(.HOLD_TICK_CYCLES(TICK)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .second_function_select(second_function_select), .input_terms(input_terms),
    .start_in(start_in), .reverse_in(reverse_in), .out_freq(out_freq),
    .running(running), .start_holding(start_holding), .decelerating(decelerating),
    .active_accel_time(acc_t), .active_decel_time(dec_t));

  term_drive_model u_model (
    .pclk(pclk), .req_second(req_second), .req_terms(req_terms), .req_start(req_start),
    .req_rev(req_rev), .second_function_select(second_function_select),
    .input_terms(input_terms),
    .start_in(start_in), .reverse_in(reverse_in), .start_holding(start_holding),
    .hold_len(hold_len));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tmo();
    n_fail++;
    $display("Error %0t: timeout", $time);
    wrap_up();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // k: 0 running, 1 holding, 2 decelerating
  task automatic wait_on(input int k, input logic v, input int lim);
    int i;
    logic s;
    i = 0;
    s = ~v;
    while (s !== v && i < lim) begin
      @(posedge pclk);
      i++;
      s = (k == 0) ? running : (k == 1) ? start_holding : decelerating;
    end
    if (s !== v) tmo();
  endtask

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {req_second, req_terms, req_start, req_rev} = 7'h00;
    ce = 1'b1;
    n_fail = 0;
    tests_run = 0;
    cyc(5);
    presetn <= 1'b1;
    rdc(OFS_CTRL, 32'h4);
    rdc(OFS_T2, 32'h270F0032);
    rdc(OFS_T3, 32'h270F270F);
    rdc(OFS_START, 32'h32);
    rdc(OFS_HOLD, 32'h270F);
    apb(1'b0, 8'h40, 32'h0, r, e);
    `CHK({e, r}, 33'h100000000)
    rdc(OFS_ACC, 32'h1F4);
    wr(OFS_CTRL, 32'h5);
    rdc(OFS_ACC, 32'h32);
    rdc(OFS_RESTART, 32'h1F4);
    wr(OFS_T1, 32'h00320003);
    rdc(OFS_ACC, 32'h4);
    rdc(OFS_DEC, 32'h32);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_T1, 32'h00320032);
    wr(OFS_BASE, 32'h2EE01770);
    rdc(OFS_GAIN, 32'h17701770);
    wr(OFS_START, 32'h1771);
    rdc(OFS_START, 32'h32);
    wr(OFS_HOLD, 32'h65);
    rdc(OFS_HOLD, 32'h270F);
    wr(OFS_T2, 32'h270F0014);
    wr(OFS_T3, 32'h0028001E);
    wr(OFS_TERM, 32'h0309);
    for (int k = 0; k < 5; k++) begin
      {req_second, req_terms} <= SEL[k];
      cyc(10);
      `CHK({acc_t, dec_t}, {EXA[k], EXD[k]})
    end
    wr(OFS_T3, 32'h270F001E);
    {req_second, req_terms} <= 5'h01;
    cyc(10);
    `CHK({acc_t, dec_t}, {32'h12C, 32'h12C})
    wr(OFS_T3, 32'h0028270F);
    {req_second, req_terms} <= 5'h11;
    cyc(10);
    `CHK(acc_t, 32'hC8)
    {req_second, req_terms} <= 5'h00;
    wr(OFS_START, 32'h1F4);
    wr(OFS_HOLD, 32'h2);
    wr(OFS_CMD, 32'h3E8);
    req_start <= 1'b1;
    wait_on(1, 1'b1, 40);
    `CHK(out_freq, 16'h1F4)
    wait_on(0, 1'b1, 40);
    cyc(2);
    `CHK(out_freq, 16'h3E8)
    `CHK(hold_len, 16'(2 * TICK + 1))
    saw_s = 1'b0;
    saw_h = 1'b0;
    req_rev <= 1'b1;
    repeat (20) begin
      @(posedge pclk);
      if (out_freq === 16'h1F4) saw_s = 1'b1;
      if (start_holding === 1'b1) saw_h = 1'b1;
    end
    `CHK({saw_s, saw_h}, 2'b10)
    req_start <= 1'b0;
    wait_on(2, 1'b1, 20);
    wait_on(0, 1'b0, 20);
    req_rev <= 1'b0;
    wr(OFS_HOLD, 32'h32);
    req_start <= 1'b1;
    wait_on(1, 1'b1, 40);
    cyc(3);
    req_start <= 1'b0;
    wait_on(2, 1'b1, 10);
    `CHK(start_holding, 1'b0)
    cyc(5);
    wr(OFS_START, 32'h0);
    req_start <= 1'b1;
    wait_on(1, 1'b1, 40);
    `CHK(out_freq, 16'h1)
    req_start <= 1'b0;
    wait_on(2, 1'b1, 10);
    cyc(5);
    wr(OFS_START, 32'h1F4);
    wr(OFS_HOLD, 32'h270F);
    wr(OFS_CMD, 32'h190);
    req_start <= 1'b1;
    cyc(30);
    `CHK({running, start_holding}, 2'b00)
    wr(OFS_CMD, 32'h258);
    wait_on(0, 1'b1, 40);
    req_start <= 1'b0;
    wait_on(0, 1'b0, 20);
    wr(OFS_START, 32'h03E801F4);
    wr(OFS_CMD, 32'h0);
    req_start <= 1'b1;
    wait_on(0, 1'b1, 40);
    cyc(3);
    `CHK(out_freq, 16'h3E8)
    ce <= 1'b0;
    req_start <= 1'b0;
    cyc(12);
    `CHK({running, out_freq}, {1'b1, 16'h3E8})
    ce <= 1'b1;
    wait_on(0, 1'b0, 20);
    wr(OFS_CTRL, 32'h6);
    wr(OFS_CMD, 32'h2EE0);
    rdc(OFS_ACC, 32'h48E);
    rdc(OFS_DEC, 32'h48E);
    wr(OFS_CMD, 32'h1770);
    rdc(OFS_ACC, 32'h1F4);
    wrap_up();
  end
endmodule
